// >>> core/ussm_pkg.sv
// Shared constants for the synchronous serial port block
package ussm_pkg;

    // ----------------------------------------------------------------
    // Register map (word index on the plain register port)
    // ----------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam logic [3:0] IDX_INTERRUPT_CONTROL = 4'h0;
    localparam logic [3:0] IDX_PERIPHERAL_IRQ_FLAGS_1 = 4'h1;
    localparam logic [3:0] IDX_PERIPHERAL_IRQ_ENABLES_1 = 4'h2;
    localparam logic [3:0] IDX_PERIPHERAL_IRQ_PRIORITY_1 = 4'h3;
    localparam logic [3:0] IDX_RECEIVE_STATUS_CONTROL = 4'h4;
    localparam logic [3:0] IDX_RECEIVE_BUFFER = 4'h5;
    localparam logic [3:0] IDX_TRANSMIT_STATUS_CONTROL = 4'h6;
    localparam logic [3:0] IDX_BAUD_RATE_DIVISOR = 4'h7;
    localparam logic [3:0] IDX_TRANSMIT_BUFFER = 4'h8;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_INTERRUPT_CONTROL = 8'h00;
    localparam logic [7:0] RST_PERIPHERAL_IRQ_FLAGS_1 = 8'h00;
    localparam logic [7:0] RST_PERIPHERAL_IRQ_ENABLES_1 = 8'h00;
    localparam logic [7:0] RST_PERIPHERAL_IRQ_PRIORITY_1 = 8'h00;
    localparam logic [7:0] RST_RECEIVE_STATUS_CONTROL = 8'h00;
    localparam logic [7:0] RST_RECEIVE_BUFFER = 8'h00;
    localparam logic [7:0] RST_TRANSMIT_STATUS_CONTROL = 8'h02;
    localparam logic [7:0] RST_BAUD_RATE_DIVISOR = 8'h00;
    localparam logic [7:0] RST_TRANSMIT_BUFFER = 8'h00;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int B_GLOBAL_IRQ_ENABLE = 7;
    localparam int B_PERIPHERAL_IRQ_ENABLE = 6;
    localparam int B_RECEIVE_IRQ = 5;
    localparam int B_TRANSMIT_IRQ = 4;
    localparam int B_SERIAL_PORT_ENABLE = 7;
    localparam int B_NINE_BIT_RECEIVE_SELECT = 6;
    localparam int B_SINGLE_RECEIVE_ENABLE = 5;
    localparam int B_CONTINUOUS_RECEIVE_ENABLE = 4;
    localparam int B_ADDRESS_DETECT_ENABLE = 3;
    localparam int B_FRAMING_ERROR_FLAG = 2;
    localparam int B_OVERRUN_ERROR_FLAG = 1;
    localparam int B_RECEIVED_NINTH_BIT = 0;
    localparam int B_CLOCK_SOURCE_SELECT = 7;
    localparam int B_NINE_BIT_TRANSMIT_SELECT = 6;
    localparam int B_TRANSMIT_ENABLE = 5;
    localparam int B_SYNC_MODE_SELECT = 4;
    localparam int B_HIGH_SPEED_BAUD_SELECT = 2;
    localparam int B_SHIFT_REGISTER_EMPTY = 1;
    localparam int B_TRANSMIT_NINTH_BIT = 0;

    // ----------------------------------------------------------------
    // Word lengths and bit count constants
    // ----------------------------------------------------------------
    localparam logic [3:0] WORD_BITS_8 = 4'h8;
    localparam logic [3:0] WORD_BITS_9 = 4'h9;
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [3:0] CNT_ONE = 4'h1;

endpackage : ussm_pkg

// >>> core/ussm_top.sv
// Synchronous half-duplex serial port: master receive, slave transmit and receive
//
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/10ps
module ussm_top (
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire logic SLEEP,
    output logic IRQ,
    output logic WAKE,
    input wire logic SHIFT_CLOCK_PIN_IN,
    output logic SHIFT_CLOCK_PIN_OUT,
    output logic SHIFT_CLOCK_PIN_OE,
    input wire logic SERIAL_DATA_PIN_IN,
    output logic SERIAL_DATA_PIN_OUT,
    output logic SERIAL_DATA_PIN_OE
);

    // ----------------------------------------------------------------
    // Register storage
    // ----------------------------------------------------------------
    logic [7:0] interrupt_control_ff;
    logic [7:0] peripheral_irq_enables_1_ff;
    logic [7:0] peripheral_irq_priority_1_ff;
    logic [7:0] baud_rate_divisor_ff;
    logic [7:0] transmit_buffer_ff;
    logic [7:0] receive_buffer_ff;
    logic serial_port_enable_ff;
    logic nine_bit_receive_select_ff;
    logic single_receive_enable_ff;
    logic continuous_receive_enable_ff;
    logic address_detect_enable_ff;
    logic overrun_error_flag_ff;
    logic received_ninth_bit_ff;
    logic clock_source_select_ff;
    logic nine_bit_transmit_select_ff;
    logic transmit_enable_ff;
    logic sync_mode_select_ff;
    logic high_speed_baud_select_ff;
    logic transmit_ninth_bit_ff;
    logic receive_irq_flag_ff;
    logic transmit_irq_flag_ff;
    logic [7:0] rdata_ff;
    logic irq_ff;
    logic wake_ff;

    // Shift engine state
    logic tx_full_ff;
    logic tx_busy_ff;
    logic [8:0] transmit_shift_register_ff;
    logic [3:0] tx_cnt_ff;
    logic [3:0] tx_len_ff;
    logic [8:0] receive_shift_register_ff;
    logic [3:0] rx_cnt_ff;
    logic dt_out_ff;
    logic dt_oe_ff;
    logic ck_oe_ff;

    // Pin synchronisers and clock generator
    logic ck_meta_ff;
    logic ck_sync_ff;
    logic ck_prev_ff;
    logic dt_meta_ff;
    logic dt_sync_ff;
    logic mclk_ff;
    logic [7:0] half_cnt_ff;

    // ----------------------------------------------------------------
    // Decoded controls
    // ----------------------------------------------------------------
    logic port_on;
    logic master;
    logic rx_en;
    logic rx_act;
    logic [3:0] rx_len;
    logic gen_run;
    logic gen_tick;
    logic edge_rise;
    logic edge_fall;
    logic wr_txbuf;
    logic rd_rxbuf;
    logic tx_load;
    logic tx_last;
    logic rx_last;

    // Sync port active only with port enable and sync mode
    assign port_on = serial_port_enable_ff & sync_mode_select_ff;
    assign master = clock_source_select_ff;
    // Slave ignores single receive; continuous has precedence anyway
    assign rx_en = port_on & (continuous_receive_enable_ff
                   | (single_receive_enable_ff & master));
    // Only a busy shifter blocks reception; a pending buffer does not
    assign rx_act = rx_en & ~tx_busy_ff;
    assign rx_len = nine_bit_receive_select_ff ? ussm_pkg::WORD_BITS_9
                    : ussm_pkg::WORD_BITS_8;
    // Master clock halts with the core clock in sleep; slave keeps going
    assign gen_run = port_on & master & ~SLEEP & (tx_busy_ff | rx_act);
    assign gen_tick = (half_cnt_ff == 8'h00);
    assign edge_rise = master ? (gen_run & gen_tick & ~mclk_ff)
                       : (ck_sync_ff & ~ck_prev_ff);
    assign edge_fall = master ? (gen_run & gen_tick & mclk_ff)
                       : (~ck_sync_ff & ck_prev_ff);
    assign wr_txbuf = WR & (ADDR == ussm_pkg::IDX_TRANSMIT_BUFFER);
    assign rd_rxbuf = RD & (ADDR == ussm_pkg::IDX_RECEIVE_BUFFER);
    // Buffered word moves only when the shifter is empty and no receive runs
    assign tx_load = port_on & transmit_enable_ff & tx_full_ff & ~tx_busy_ff
                     & ~rx_en;
    assign tx_last = tx_busy_ff & edge_fall & (tx_cnt_ff == tx_len_ff - ussm_pkg::CNT_ONE);
    assign rx_last = rx_act & edge_fall & (rx_cnt_ff == rx_len - ussm_pkg::CNT_ONE);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    // Two flops before use; the third flop feeds edge detection only
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            ck_meta_ff <= 1'b0;
            ck_sync_ff <= 1'b0;
            ck_prev_ff <= 1'b0;
            dt_meta_ff <= 1'b0;
            dt_sync_ff <= 1'b0;
        end else begin
            ck_meta_ff <= SHIFT_CLOCK_PIN_IN;
            ck_sync_ff <= ck_meta_ff;
            ck_prev_ff <= ck_sync_ff;
            dt_meta_ff <= SERIAL_DATA_PIN_IN;
            dt_sync_ff <= dt_meta_ff;
        end
    end

    // ----------------------------------------------------------------
    // Master shift clock generator
    // ----------------------------------------------------------------
    // Half period is divisor plus one cycles; clock idles low when stopped
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            mclk_ff <= 1'b0;
            half_cnt_ff <= ussm_pkg::RST_BAUD_RATE_DIVISOR;
        end else if (!gen_run) begin
            mclk_ff <= 1'b0;
            half_cnt_ff <= baud_rate_divisor_ff;
        end else if (gen_tick) begin
            mclk_ff <= ~mclk_ff;
            half_cnt_ff <= baud_rate_divisor_ff;
        end else begin
            half_cnt_ff <= half_cnt_ff - 8'h01;
        end
    end

    // ----------------------------------------------------------------
    // Control register writes
    // ----------------------------------------------------------------
    // Plain read/write storage
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            interrupt_control_ff <= ussm_pkg::RST_INTERRUPT_CONTROL;
            peripheral_irq_enables_1_ff <= ussm_pkg::RST_PERIPHERAL_IRQ_ENABLES_1;
            peripheral_irq_priority_1_ff <= ussm_pkg::RST_PERIPHERAL_IRQ_PRIORITY_1;
            baud_rate_divisor_ff <= ussm_pkg::RST_BAUD_RATE_DIVISOR;
        end else if (WR) begin
            case (ADDR)
                ussm_pkg::IDX_INTERRUPT_CONTROL: interrupt_control_ff <= WDATA;
                ussm_pkg::IDX_PERIPHERAL_IRQ_ENABLES_1: peripheral_irq_enables_1_ff <= WDATA;
                ussm_pkg::IDX_PERIPHERAL_IRQ_PRIORITY_1: peripheral_irq_priority_1_ff <= WDATA;
                ussm_pkg::IDX_BAUD_RATE_DIVISOR: baud_rate_divisor_ff <= WDATA;
                default: ;
            endcase
        end
    end

    // Receive control; single receive clears itself after one word
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            serial_port_enable_ff <= 1'b0;
            nine_bit_receive_select_ff <= 1'b0;
            single_receive_enable_ff <= 1'b0;
            continuous_receive_enable_ff <= 1'b0;
            address_detect_enable_ff <= 1'b0;
        end else if (WR && ADDR == ussm_pkg::IDX_RECEIVE_STATUS_CONTROL) begin
            serial_port_enable_ff <= WDATA[ussm_pkg::B_SERIAL_PORT_ENABLE];
            nine_bit_receive_select_ff <= WDATA[ussm_pkg::B_NINE_BIT_RECEIVE_SELECT];
            single_receive_enable_ff <= WDATA[ussm_pkg::B_SINGLE_RECEIVE_ENABLE];
            continuous_receive_enable_ff <= WDATA[ussm_pkg::B_CONTINUOUS_RECEIVE_ENABLE];
            address_detect_enable_ff <= WDATA[ussm_pkg::B_ADDRESS_DETECT_ENABLE];
        end else if (rx_last && master && !continuous_receive_enable_ff) begin
            single_receive_enable_ff <= 1'b0;
        end
    end

    // Transmit control; empty flag and framing error are not writable
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            clock_source_select_ff <= 1'b0;
            nine_bit_transmit_select_ff <= 1'b0;
            transmit_enable_ff <= 1'b0;
            sync_mode_select_ff <= 1'b0;
            high_speed_baud_select_ff <= 1'b0;
            transmit_ninth_bit_ff <= 1'b0;
        end else if (WR && ADDR == ussm_pkg::IDX_TRANSMIT_STATUS_CONTROL) begin
            clock_source_select_ff <= WDATA[ussm_pkg::B_CLOCK_SOURCE_SELECT];
            nine_bit_transmit_select_ff <= WDATA[ussm_pkg::B_NINE_BIT_TRANSMIT_SELECT];
            transmit_enable_ff <= WDATA[ussm_pkg::B_TRANSMIT_ENABLE];
            sync_mode_select_ff <= WDATA[ussm_pkg::B_SYNC_MODE_SELECT];
            high_speed_baud_select_ff <= WDATA[ussm_pkg::B_HIGH_SPEED_BAUD_SELECT];
            transmit_ninth_bit_ff <= WDATA[ussm_pkg::B_TRANSMIT_NINTH_BIT];
        end
    end

    // ----------------------------------------------------------------
    // Transmit path
    // ----------------------------------------------------------------
    // Buffer holds one word; a write while full overwrites the old word
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            transmit_buffer_ff <= ussm_pkg::RST_TRANSMIT_BUFFER;
            tx_full_ff <= 1'b0;
        end else if (wr_txbuf) begin
            transmit_buffer_ff <= WDATA;
            tx_full_ff <= 1'b1;
        end else if (tx_load) begin
            tx_full_ff <= 1'b0;
        end
    end

    // Flag sets on each move into the shifter; only a buffer write clears it
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            transmit_irq_flag_ff <= 1'b0;
        end else if (tx_load) begin
            transmit_irq_flag_ff <= 1'b1;
        end else if (wr_txbuf) begin
            transmit_irq_flag_ff <= 1'b0;
        end
    end

    // Shifter: bit out after each rising edge, counted on each falling edge
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            tx_busy_ff <= 1'b0;
            transmit_shift_register_ff <= 9'h000;
            tx_cnt_ff <= ussm_pkg::CNT_ZERO;
            tx_len_ff <= ussm_pkg::WORD_BITS_8;
        end else if (tx_load) begin
            tx_busy_ff <= 1'b1;
            transmit_shift_register_ff <= {transmit_ninth_bit_ff, transmit_buffer_ff};
            tx_cnt_ff <= ussm_pkg::CNT_ZERO;
            tx_len_ff <= nine_bit_transmit_select_ff ? ussm_pkg::WORD_BITS_9
                         : ussm_pkg::WORD_BITS_8;
        end else if (!port_on || !transmit_enable_ff) begin
            tx_busy_ff <= 1'b0; // Disable aborts the word in flight
            tx_cnt_ff <= ussm_pkg::CNT_ZERO;
        end else if (tx_last) begin
            tx_busy_ff <= 1'b0;
            tx_cnt_ff <= ussm_pkg::CNT_ZERO;
        end else if (tx_busy_ff && edge_fall) begin
            tx_cnt_ff <= tx_cnt_ff + ussm_pkg::CNT_ONE;
        end
    end

    // Data pin driver; released between words so the line can be received
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            dt_out_ff <= 1'b0;
            dt_oe_ff <= 1'b0;
        end else if (tx_load) begin
            dt_out_ff <= transmit_buffer_ff[0];
            dt_oe_ff <= 1'b1;
        end else if (!tx_busy_ff || tx_last || !port_on || !transmit_enable_ff) begin
            dt_oe_ff <= 1'b0;
        end else if (edge_rise) begin
            dt_out_ff <= transmit_shift_register_ff[tx_cnt_ff];
        end
    end

    // Clock pin is driven only as master
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            ck_oe_ff <= 1'b0;
        end else begin
            ck_oe_ff <= port_on & master;
        end
    end

    // ----------------------------------------------------------------
    // Receive path
    // ----------------------------------------------------------------
    // Sample on falling edges; a dropped enable discards the partial word
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            receive_shift_register_ff <= 9'h000;
            rx_cnt_ff <= ussm_pkg::CNT_ZERO;
        end else if (!rx_act) begin
            rx_cnt_ff <= ussm_pkg::CNT_ZERO;
        end else if (edge_fall) begin
            receive_shift_register_ff[rx_cnt_ff] <= dt_sync_ff;
            rx_cnt_ff <= rx_last ? ussm_pkg::CNT_ZERO : rx_cnt_ff + ussm_pkg::CNT_ONE;
        end
    end

    // Finished word moves to the buffer unless the last one is unread
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            receive_buffer_ff <= ussm_pkg::RST_RECEIVE_BUFFER;
            received_ninth_bit_ff <= 1'b0;
        end else if (rx_last && !receive_irq_flag_ff) begin
            // Eighth bit of a short word is still on the synced line this cycle
            receive_buffer_ff <= nine_bit_receive_select_ff ? receive_shift_register_ff[7:0]
                                 : {dt_sync_ff, receive_shift_register_ff[6:0]};
            received_ninth_bit_ff <= nine_bit_receive_select_ff ? dt_sync_ff : 1'b0;
        end
    end

    // Receive flag: a word finishing in the read cycle keeps it set
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            receive_irq_flag_ff <= 1'b0;
        end else if (rx_last) begin
            receive_irq_flag_ff <= 1'b1;
        end else if (rd_rxbuf) begin
            receive_irq_flag_ff <= 1'b0;
        end
    end

    // Overrun: word lost on a full buffer; cleared by dropping continuous
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            overrun_error_flag_ff <= 1'b0;
        end else if (rx_last && receive_irq_flag_ff) begin
            overrun_error_flag_ff <= 1'b1;
        end else if (!continuous_receive_enable_ff) begin
            overrun_error_flag_ff <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Interrupt request and wake
    // ----------------------------------------------------------------
    // Wake needs only the peripheral enables; the request also needs globals
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            irq_ff <= 1'b0;
            wake_ff <= 1'b0;
        end else begin
            irq_ff <= interrupt_control_ff[ussm_pkg::B_GLOBAL_IRQ_ENABLE]
                      & interrupt_control_ff[ussm_pkg::B_PERIPHERAL_IRQ_ENABLE]
                      & ((receive_irq_flag_ff
                          & peripheral_irq_enables_1_ff[ussm_pkg::B_RECEIVE_IRQ])
                         | (transmit_irq_flag_ff
                            & peripheral_irq_enables_1_ff[ussm_pkg::B_TRANSMIT_IRQ]));
            wake_ff <= SLEEP
                       & ((receive_irq_flag_ff
                           & peripheral_irq_enables_1_ff[ussm_pkg::B_RECEIVE_IRQ])
                          | (transmit_irq_flag_ff
                             & peripheral_irq_enables_1_ff[ussm_pkg::B_TRANSMIT_IRQ]));
        end
    end

    // ----------------------------------------------------------------
    // Register reads
    // ----------------------------------------------------------------
    // Read data stands one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            rdata_ff <= 8'h00;
        end else if (RD) begin
            case (ADDR)
                ussm_pkg::IDX_INTERRUPT_CONTROL: rdata_ff <= interrupt_control_ff;
                ussm_pkg::IDX_PERIPHERAL_IRQ_FLAGS_1:
                    rdata_ff <= {2'b00, receive_irq_flag_ff, transmit_irq_flag_ff, 4'h0};
                ussm_pkg::IDX_PERIPHERAL_IRQ_ENABLES_1: rdata_ff <= peripheral_irq_enables_1_ff;
                ussm_pkg::IDX_PERIPHERAL_IRQ_PRIORITY_1: rdata_ff <= peripheral_irq_priority_1_ff;
                ussm_pkg::IDX_RECEIVE_STATUS_CONTROL:
                    rdata_ff <= {serial_port_enable_ff, nine_bit_receive_select_ff,
                                 single_receive_enable_ff, continuous_receive_enable_ff,
                                 address_detect_enable_ff, 1'b0, overrun_error_flag_ff,
                                 received_ninth_bit_ff};
                ussm_pkg::IDX_RECEIVE_BUFFER: rdata_ff <= receive_buffer_ff;
                ussm_pkg::IDX_TRANSMIT_STATUS_CONTROL:
                    rdata_ff <= {clock_source_select_ff, nine_bit_transmit_select_ff,
                                 transmit_enable_ff, sync_mode_select_ff, 1'b0,
                                 high_speed_baud_select_ff, ~tx_busy_ff,
                                 transmit_ninth_bit_ff};
                ussm_pkg::IDX_BAUD_RATE_DIVISOR: rdata_ff <= baud_rate_divisor_ff;
                ussm_pkg::IDX_TRANSMIT_BUFFER: rdata_ff <= transmit_buffer_ff;
                default: rdata_ff <= 8'h00;
            endcase
        end else begin
            rdata_ff <= 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign RDATA = rdata_ff;
    assign IRQ = irq_ff;
    assign WAKE = wake_ff;
    assign SHIFT_CLOCK_PIN_OUT = mclk_ff;
    assign SHIFT_CLOCK_PIN_OE = ck_oe_ff;
    assign SERIAL_DATA_PIN_OUT = dt_out_ff;
    assign SERIAL_DATA_PIN_OE = dt_oe_ff;

endmodule : ussm_top

// >>> tb/ussm_props.sv
// Port checker for the serial port block
`timescale 1ns/10ps
module ussm_props (
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic RD,
    input wire logic WR,
    input wire logic [7:0] RDATA,
    input wire logic SLEEP,
    input wire logic IRQ,
    input wire logic WAKE,
    input wire logic SHIFT_CLOCK_PIN_IN,
    input wire logic SHIFT_CLOCK_PIN_OE,
    input wire logic SERIAL_DATA_PIN_OUT,
    input wire logic SERIAL_DATA_PIN_OE
);
    // ------------
    // Properties
    // ------------
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SYS_RST);
    a_rd_quiet: assert property (!$past(RD) |-> RDATA == 8'h00) else $error("rdata");
    a_wake_awake: assert property (!SLEEP |=> !WAKE) else $error("wake awake");
    a_wake_cause: assert property ($rose(WAKE) |-> $past(SLEEP)) else $error("wake");
    a_irq_wakes: assert property (IRQ && $past(SLEEP) |-> WAKE) else $error("no wake");
    a_reset_quiet: assert property ($past(SYS_RST) |-> !IRQ && !SERIAL_DATA_PIN_OE)
        else $error("reset");
    // Data may only move while the shift clock is high
    a_data_hold: assert property ((!SHIFT_CLOCK_PIN_IN) [*3] ##0 $past(SERIAL_DATA_PIN_OE)
        |-> $stable(SERIAL_DATA_PIN_OUT) || !SERIAL_DATA_PIN_OE) else $error("data moved");
    a_clk_cfg: assert property (!$past(WR) && !$past(WR, 2) |-> $stable(SHIFT_CLOCK_PIN_OE))
        else $error("clock enable");
    a_word_len: assert property ($rose(SERIAL_DATA_PIN_OE) |-> SERIAL_DATA_PIN_OE [*8])
        else $error("word short");
    c_wake: cover property ($rose(WAKE));
    c_tx: cover property ($rose(SERIAL_DATA_PIN_OE));
    c_master: cover property ($rose(SHIFT_CLOCK_PIN_OE));
endmodule : ussm_props
bind ussm_top ussm_props u_props (
    .CLOCK(CLOCK),
    .SYS_RST(SYS_RST),
    .RD(RD),
    .WR(WR),
    .RDATA(RDATA),
    .SLEEP(SLEEP),
    .IRQ(IRQ),
    .WAKE(WAKE),
    .SHIFT_CLOCK_PIN_IN(SHIFT_CLOCK_PIN_IN),
    .SHIFT_CLOCK_PIN_OE(SHIFT_CLOCK_PIN_OE),
    .SERIAL_DATA_PIN_OUT(SERIAL_DATA_PIN_OUT),
    .SERIAL_DATA_PIN_OE(SERIAL_DATA_PIN_OE)
);

// >>> tb/ussm_peer.sv
// Behavioural synchronous serial peer on the clock and data lines
`timescale 1ns/10ps
module ussm_peer (
    output logic sck,
    output logic sdo,
    input wire logic sdi
);
    logic [7:0] got;
    // Clock stands low between frames
    initial sck = 1'b0;
    initial sdo = 1'b0;
    // Data moves mid-low so it never races the falling edge
    task automatic xfer(input logic [7:0] wd);
        #25; // Keeps pin changes off the system clock edges
        for (int i = 0; i < 8; i++) begin
            #200 sdo = wd[i];
            #200 sck = 1'b1;
            #400 sck = 1'b0;
            got[i] = sdi;
        end
        #200 sdo = ~wd[7]; // Line left at the inverse of the last bit
    endtask : xfer
endmodule : ussm_peer

// >>> tb/usart_sync_rx_and_slave_mode_tb.sv
// Self-checking bench for the serial port block
`timescale 1ns/10ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin n_errors++; \
    $display("Error %s expected %h seen %h", n, e, s); end end
module usart_sync_rx_and_slave_mode_tb;
    logic CLOCK = 1'b0, SYS_RST = 1'b1, WR = 1'b0, RD = 1'b0, SLEEP = 1'b0;
    logic [3:0] ADDR = 4'h0;
    logic [7:0] WDATA = 8'h00, RDATA, w, v;
    logic IRQ, WAKE, SHIFT_CLOCK_PIN_OUT, SHIFT_CLOCK_PIN_OE;
    logic SERIAL_DATA_PIN_OUT, SERIAL_DATA_PIN_OE, sck, sdo;
    int n_errors = 0;
    int checks_done = 0;
    // Pin levels from the block's enables; otherwise the peer drives
    wire SHIFT_CLOCK_PIN_IN = SHIFT_CLOCK_PIN_OE ? SHIFT_CLOCK_PIN_OUT : sck;
    wire SERIAL_DATA_PIN_IN = SERIAL_DATA_PIN_OE ? SERIAL_DATA_PIN_OUT : sdo;
    ussm_top dut (
        .CLOCK(CLOCK),
        .SYS_RST(SYS_RST),
        .ADDR(ADDR),
        .WDATA(WDATA),
        .WR(WR),
        .RD(RD),
        .RDATA(RDATA),
        .SLEEP(SLEEP),
        .IRQ(IRQ),
        .WAKE(WAKE),
        .SHIFT_CLOCK_PIN_IN(SHIFT_CLOCK_PIN_IN),
        .SHIFT_CLOCK_PIN_OUT(SHIFT_CLOCK_PIN_OUT),
        .SHIFT_CLOCK_PIN_OE(SHIFT_CLOCK_PIN_OE),
        .SERIAL_DATA_PIN_IN(SERIAL_DATA_PIN_IN),
        .SERIAL_DATA_PIN_OUT(SERIAL_DATA_PIN_OUT),
        .SERIAL_DATA_PIN_OE(SERIAL_DATA_PIN_OE)
    );
    ussm_peer peer (.sck(sck), .sdo(sdo), .sdi(SERIAL_DATA_PIN_IN));
    always #50 CLOCK = ~CLOCK;
    // Expected flag register from the two flags
    function automatic logic [7:0] flg(input logic r, input logic t);
        return {2'b00, r, t, 4'h0};
    endfunction : flg
    // One-cycle bus strokes
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge CLOCK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLOCK);
        WR <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] e, input string n);
        @(posedge CLOCK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLOCK);
        RD <= 1'b0;
        #1 `CHK(n, e, RDATA)
    endtask : rd
    task automatic stop_test;
        $display("Checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : stop_test
    // Hang guard, far beyond the run of about 71 us
    initial begin
        #400_000 n_errors++;
        stop_test();
    end
    // Slave receive in sleep, slave transmit, master single receive
    initial begin
        void'($urandom(91053));
        repeat (8) @(posedge CLOCK);
        SYS_RST <= 1'b0;
        rd(4'h6, 8'h02, "transmit_status_control reset");
        rd(4'h9, 8'h00, "unmapped");
        wr(4'h6, 8'h10);
        wr(4'h2, 8'h30);
        wr(4'h0, 8'hC0);
        wr(4'h4, 8'h90);
        for (int k = 0; k < 3; k++) begin
            w = (k == 0) ? 8'h80 : 8'($urandom);
            @(posedge CLOCK) SLEEP <= 1'b1;
            peer.xfer(w);
            repeat (8) @(posedge CLOCK);
            #1 `CHK("wake", 1'b1, WAKE)
            `CHK("irq", 1'b1, IRQ)
            @(posedge CLOCK) SLEEP <= 1'b0;
            rd(4'h4, 8'h90, "receive_status_control");
            rd(4'h5, w, "rx word");
        end
        // Second word meets an unread buffer and is lost
        peer.xfer(w);
        peer.xfer(8'h5A);
        repeat (8) @(posedge CLOCK);
        rd(4'h4, 8'h92, "overrun");
        wr(4'h4, 8'hA0);
        rd(4'h4, 8'hA0, "error cleared");
        rd(4'h5, w, "kept word");
        peer.xfer(8'h5A);
        repeat (8) @(posedge CLOCK);
        rd(4'h1, flg(1'b0, 1'b0), "single ignored");
        $display("Test slave receive done");
        w = 8'($urandom);
        v = 8'($urandom);
        wr(4'h4, 8'h80);
        wr(4'h6, 8'h30);
        wr(4'h8, w);
        repeat (3) @(posedge CLOCK);
        wr(4'h8, v);
        @(posedge CLOCK) SLEEP <= 1'b1;
        rd(4'h1, flg(1'b0, 1'b0), "second waits");
        rd(4'h6, 8'h30, "shifter busy");
        peer.xfer(8'h00);
        `CHK("tx first", w, peer.got)
        repeat (8) @(posedge CLOCK);
        #1 `CHK("tx wake", 1'b1, WAKE)
        rd(4'h1, flg(1'b0, 1'b1), "buffer moved");
        peer.xfer(8'h00);
        `CHK("tx second", v, peer.got)
        repeat (8) @(posedge CLOCK);
        rd(4'h6, 8'h32, "shifter empty");
        @(posedge CLOCK) SLEEP <= 1'b0;
        $display("Test slave transmit done");
        rd(4'h4, 8'h80, "enables clear");
        wr(4'h6, 8'h90);
        wr(4'h4, 8'hE0);
        repeat (40) @(posedge CLOCK);
        rd(4'h1, flg(1'b1, 1'b1), "rx flag");
        rd(4'h4, {7'h60, sdo}, "single ends");
        rd(4'h5, {8{sdo}}, "master word");
        `CHK("clock drive", 1'b1, SHIFT_CLOCK_PIN_OE)
        $display("Test master receive done");
        stop_test();
    end
endmodule : usart_sync_rx_and_slave_mode_tb
